// file: logic/scsc_defines.svh
// Constants for the special cycle and stop control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SCSC_DEFINES_SVH
`define SCSC_DEFINES_SVH
`define SCSC_BE_STOP_GRANT 8'hFB
`define SCSC_BE_FLUSH_ACK 8'hEF
`define SCSC_BE_WRITEBACK 8'hF7
`define SCSC_BE_HALT 8'hFB
`define SCSC_BE_FLUSH 8'hFD
`define SCSC_BE_SHUTDOWN 8'hFE
`define SCSC_BE_IDLE 8'hFF
`define SCSC_A43_STOP_GRANT 2'h2
`define SCSC_A43_OTHER 2'h0
`define SCSC_RESET_VECTOR 32'hFFFFFFF0
`define SCSC_CLK_PERIOD_NS 40
`define SCSC_ASYNC_MIN_CLKS 2
`define SCSC_INIT_IO_LEAD_CLKS 3
`define SCSC_CACHE_WALK_CLKS 4'h8
`endif

// file: logic/scsc_pkg.sv
// Types shared by both ends of the special cycle link.
// Assumes nothing beyond a SystemVerilog compiler.
package scsc_pkg;
  typedef enum logic [2:0] {
    SCSC_CYC_STOP_GRANT = 3'h0,
    SCSC_CYC_FLUSH_ACK = 3'h1,
    SCSC_CYC_WRITEBACK = 3'h2,
    SCSC_CYC_HALT = 3'h3,
    SCSC_CYC_FLUSH = 3'h4,
    SCSC_CYC_SHUTDOWN = 3'h5
  } scsc_cyc_t;
  typedef enum logic [3:0] {
    SCSC_ST_RUN = 4'h0,
    SCSC_ST_CACHE = 4'h1,
    SCSC_ST_ISSUE = 4'h2,
    SCSC_ST_WAIT = 4'h3,
    SCSC_ST_HALTED = 4'h4,
    SCSC_ST_SHUTDOWN = 4'h5,
    SCSC_ST_STOP_GRANT = 4'h6,
    SCSC_ST_INIT = 4'h7,
    SCSC_ST_RESET = 4'h8
  } scsc_state_t;
endpackage

// file: logic/scsc_if.sv
// Link between the device end and the chipset end.
// Assumes one shared bus clock; all signals are active as named.
interface scsc_if;
  logic addr_strobe_n;
  logic [7:0] byte_enables_n;
  logic [31:3] addr;
  logic data_code;
  logic mem_io;
  logic write_read;
  logic burst_ready_n;
  logic stop_clock_req_n;
  logic flush_n;
  logic init;
  logic nmi;
  logic sys_mgmt_irq_n;
  logic ext_write_buf_empty_n;
  modport device (
    output addr_strobe_n, byte_enables_n, addr, data_code, mem_io, write_read,
    input burst_ready_n, stop_clock_req_n, flush_n, init, nmi, sys_mgmt_irq_n,
    input ext_write_buf_empty_n
  );
  modport chipset (
    input addr_strobe_n, byte_enables_n, addr, data_code, mem_io, write_read,
    output burst_ready_n, stop_clock_req_n, flush_n, init, nmi, sys_mgmt_irq_n,
    output ext_write_buf_empty_n
  );
endinterface

// file: logic/scsc_device.sv
// Device end: issues special bus cycles and tracks halt, shutdown, stop grant,
// init and reset states. Assumes the chipset answers each cycle with ready.
`include "scsc_defines.svh"
module scsc_device (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Link to chipset
  scsc_if.device bus,
  // Core side
  input wire logic instr_boundary_in,
  input wire logic halt_instr_in,
  input wire logic writeback_invalidate_instr_in,
  input wire logic invalidate_instr_in,
  input wire logic triple_fault_in,
  input wire logic bus_pending_in,
  input wire logic ext_write_buf_empty_n_mask_in,
  output logic pipe_flush_out,
  output logic cache_writeback_out,
  output logic cache_invalidate_out,
  output logic fetch_start_out,
  output logic [31:0] fetch_addr_out,
  output logic init_keep_state_out,
  output logic internal_clk_stopped_out,
  output logic halted_out,
  output logic shutdown_out
);
  import scsc_pkg::*;

  scsc_state_t state_r;
  scsc_cyc_t cyc_r;
  logic stop_req_r;
  logic init_req_r;
  logic flush_req_r;
  logic pend_wb_r;
  logic [3:0] walk_r;
  logic ads_n_r;
  logic [7:0] be_n_r;
  logic [4:3] a43_r;
  logic spec_r;
  logic wake;

  assign wake = bus.nmi || bus.init || !bus.sys_mgmt_irq_n;

  // ==========================================================
  // Input latching
  // Init and flush requests are sampled every edge but held until a boundary takes them; stop follows its pin.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stop_req_r <= 1'b0;
      init_req_r <= 1'b0;
      flush_req_r <= 1'b0;
    end else begin
      stop_req_r <= !bus.stop_clock_req_n;
      if (bus.init) begin
        init_req_r <= 1'b1;
      end else if (state_r == SCSC_ST_INIT) begin
        init_req_r <= 1'b0;
      end
      if (!bus.flush_n) begin
        flush_req_r <= 1'b1;
      end else if (state_r == SCSC_ST_CACHE && cyc_r == SCSC_CYC_FLUSH_ACK) begin
        flush_req_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_r <= SCSC_ST_RESET;
      cyc_r <= SCSC_CYC_HALT;
      pend_wb_r <= 1'b0;
      walk_r <= 4'h0;
      ads_n_r <= 1'b1;
      be_n_r <= `SCSC_BE_IDLE;
      a43_r <= `SCSC_A43_OTHER;
      spec_r <= 1'b0;
      pipe_flush_out <= 1'b1;
      cache_writeback_out <= 1'b0;
      cache_invalidate_out <= 1'b1;
      fetch_start_out <= 1'b0;
      fetch_addr_out <= `SCSC_RESET_VECTOR;
      init_keep_state_out <= 1'b0;
      internal_clk_stopped_out <= 1'b0;
      halted_out <= 1'b0;
      shutdown_out <= 1'b0;
    end else begin
      fetch_start_out <= 1'b0;
      pipe_flush_out <= 1'b0;
      ads_n_r <= 1'b1;
      unique case (state_r)
        SCSC_ST_RESET: begin
          cache_invalidate_out <= 1'b0;
          fetch_start_out <= 1'b1;
          state_r <= SCSC_ST_RUN;
        end
        SCSC_ST_RUN: begin
          if (triple_fault_in) begin
            cyc_r <= SCSC_CYC_SHUTDOWN;
            state_r <= SCSC_ST_ISSUE;
          end else if (instr_boundary_in && init_req_r) begin
            pipe_flush_out <= 1'b1;
            state_r <= SCSC_ST_INIT;
          end else if (instr_boundary_in && flush_req_r) begin
            cyc_r <= SCSC_CYC_FLUSH_ACK;
            walk_r <= `SCSC_CACHE_WALK_CLKS;
            // Walk strobes rise on entry so they stand for every walk cycle.
            cache_writeback_out <= 1'b1;
            cache_invalidate_out <= 1'b1;
            state_r <= SCSC_ST_CACHE;
          end else if (instr_boundary_in && stop_req_r) begin
            pipe_flush_out <= 1'b1;
            cyc_r <= SCSC_CYC_STOP_GRANT;
            state_r <= SCSC_ST_ISSUE;
          end else if (writeback_invalidate_instr_in) begin
            cyc_r <= SCSC_CYC_WRITEBACK;
            walk_r <= `SCSC_CACHE_WALK_CLKS;
            pend_wb_r <= 1'b1;
            cache_writeback_out <= 1'b1;
            cache_invalidate_out <= 1'b1;
            state_r <= SCSC_ST_CACHE;
          end else if (invalidate_instr_in) begin
            cyc_r <= SCSC_CYC_FLUSH;
            walk_r <= 4'h1;
            cache_invalidate_out <= 1'b1;
            state_r <= SCSC_ST_CACHE;
          end else if (halt_instr_in) begin
            cyc_r <= SCSC_CYC_HALT;
            state_r <= SCSC_ST_ISSUE;
          end
        end
        SCSC_ST_CACHE: begin
          // Flush ack and writeback write back dirty lines first; invalidate only drops them.
          cache_writeback_out <= (cyc_r != SCSC_CYC_FLUSH);
          cache_invalidate_out <= 1'b1;
          if (walk_r == 4'h1) begin
            cache_writeback_out <= 1'b0;
            cache_invalidate_out <= 1'b0;
            state_r <= SCSC_ST_ISSUE;
          end
          walk_r <= walk_r - 4'h1;
        end
        SCSC_ST_ISSUE: begin
          // Pending cycles drain first; shutdown abandons bus activity at once.
          if (!bus_pending_in || cyc_r == SCSC_CYC_SHUTDOWN) begin
            ads_n_r <= 1'b0;
            spec_r <= 1'b1;
            a43_r <= (cyc_r == SCSC_CYC_STOP_GRANT) ?
              `SCSC_A43_STOP_GRANT : `SCSC_A43_OTHER;
            unique case (cyc_r)
              SCSC_CYC_STOP_GRANT: be_n_r <= `SCSC_BE_STOP_GRANT;
              SCSC_CYC_FLUSH_ACK: be_n_r <= `SCSC_BE_FLUSH_ACK;
              SCSC_CYC_WRITEBACK: be_n_r <= `SCSC_BE_WRITEBACK;
              SCSC_CYC_HALT: be_n_r <= `SCSC_BE_HALT;
              SCSC_CYC_FLUSH: be_n_r <= `SCSC_BE_FLUSH;
              SCSC_CYC_SHUTDOWN: be_n_r <= `SCSC_BE_SHUTDOWN;
            endcase
            state_r <= SCSC_ST_WAIT;
          end
        end
        SCSC_ST_WAIT: begin
          if (!bus.burst_ready_n) begin
            spec_r <= 1'b0;
            be_n_r <= `SCSC_BE_IDLE;
            a43_r <= `SCSC_A43_OTHER;
            if (cyc_r == SCSC_CYC_WRITEBACK && pend_wb_r) begin
              // Writeback instruction also announces the invalidation.
              pend_wb_r <= 1'b0;
              cyc_r <= SCSC_CYC_FLUSH;
              state_r <= SCSC_ST_ISSUE;
            end else if (cyc_r == SCSC_CYC_SHUTDOWN) begin
              shutdown_out <= 1'b1;
              state_r <= SCSC_ST_SHUTDOWN;
            end else if (cyc_r == SCSC_CYC_HALT) begin
              halted_out <= 1'b1;
              state_r <= SCSC_ST_HALTED;
            end else if (cyc_r == SCSC_CYC_STOP_GRANT) begin
              state_r <= SCSC_ST_STOP_GRANT;
            end else begin
              state_r <= SCSC_ST_RUN;
            end
          end
        end
        SCSC_ST_HALTED: begin
          if (wake || stop_req_r || !bus.flush_n) begin
            halted_out <= 1'b0;
            state_r <= SCSC_ST_RUN;
          end
        end
        SCSC_ST_SHUTDOWN: begin
          if (wake) begin
            shutdown_out <= 1'b0;
            state_r <= SCSC_ST_RUN;
          end
        end
        SCSC_ST_STOP_GRANT: begin
          // Write buffer gating may be masked; clock stays stopped while requested.
          if (stop_req_r && (ext_write_buf_empty_n_mask_in || !bus.ext_write_buf_empty_n)) begin
            internal_clk_stopped_out <= 1'b1;
          end
          if (!stop_req_r) begin
            internal_clk_stopped_out <= 1'b0;
            state_r <= SCSC_ST_RUN;
          end
        end
        SCSC_ST_INIT: begin
          // Caches, FP state and counters are kept; only core state restarts.
          init_keep_state_out <= 1'b1;
          fetch_start_out <= 1'b1;
          state_r <= SCSC_ST_RUN;
        end
        default: state_r <= SCSC_ST_RESET;
      endcase
    end
  end

  assign bus.addr_strobe_n = ads_n_r;
  assign bus.byte_enables_n = be_n_r;
  assign bus.addr = {27'h0, a43_r};
  assign bus.data_code = 1'b0;
  assign bus.mem_io = 1'b0;
  assign bus.write_read = spec_r;
endmodule // scsc_device

// file: logic/scsc_chipset.sv
// Chipset end: acknowledges special cycles and drives the control inputs.
// Assumes user-side requests are synchronous to clock_in.
`include "scsc_defines.svh"
module scsc_chipset (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Link to device
  scsc_if.chipset bus,
  // User side
  input wire logic stop_req_in,
  input wire logic flush_req_in,
  input wire logic init_req_in,
  input wire logic nmi_in,
  input wire logic smi_in,
  input wire logic wbuf_empty_in,
  output logic cycle_seen_out,
  output logic [7:0] cycle_be_n_out,
  output logic [1:0] cycle_a43_out,
  output logic grant_done_out
);
  import scsc_pkg::*;

  logic rdy_n_r;
  logic stop_n_r;
  logic flush_n_r;
  logic init_r;
  logic nmi_r;
  logic smi_n_r;
  logic ext_write_buf_empty_n_n_r;
  logic granted_r;

  // ==========================================================
  // Ready answers one cycle after each strobe.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdy_n_r <= 1'b1;
      cycle_seen_out <= 1'b0;
      cycle_be_n_out <= `SCSC_BE_IDLE;
      cycle_a43_out <= `SCSC_A43_OTHER;
      grant_done_out <= 1'b0;
    end else begin
      rdy_n_r <= bus.addr_strobe_n;
      cycle_seen_out <= !bus.addr_strobe_n;
      if (!bus.addr_strobe_n) begin
        cycle_be_n_out <= bus.byte_enables_n;
        cycle_a43_out <= bus.addr[4:3];
      end
      grant_done_out <= !rdy_n_r && cycle_be_n_out == `SCSC_BE_STOP_GRANT &&
        cycle_a43_out == `SCSC_A43_STOP_GRANT;
    end
  end

  // ==========================================================
  // Control inputs, registered so they are synchronous to the device.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stop_n_r <= 1'b1;
      flush_n_r <= 1'b1;
      init_r <= 1'b0;
      nmi_r <= 1'b0;
      smi_n_r <= 1'b1;
      ext_write_buf_empty_n_n_r <= 1'b1;
      granted_r <= 1'b0;
    end else begin
      // A granted request is not held again, or it could never be released.
      if (grant_done_out) begin
        granted_r <= 1'b1;
      end else if (stop_n_r) begin
        granted_r <= 1'b0;
      end
      // Request is held until the grant has completed.
      stop_n_r <= !(stop_req_in || (!stop_n_r && !granted_r && !grant_done_out));
      flush_n_r <= !flush_req_in;
      init_r <= init_req_in;
      nmi_r <= nmi_in;
      smi_n_r <= !smi_in;
      ext_write_buf_empty_n_n_r <= !wbuf_empty_in;
    end
  end

  assign bus.burst_ready_n = rdy_n_r;
  assign bus.stop_clock_req_n = stop_n_r;
  assign bus.flush_n = flush_n_r;
  assign bus.init = init_r;
  assign bus.nmi = nmi_r;
  assign bus.sys_mgmt_irq_n = smi_n_r;
  assign bus.ext_write_buf_empty_n = ext_write_buf_empty_n_n_r;
endmodule // scsc_chipset

// file: sim/scsc_assertions.sv
// Concurrent checks on the special cycle link between the two ends.
// Assumes it is instantiated beside the interface and sees its signals.
module scsc_assertions (
  // Clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // Link signals
  input wire logic addr_strobe_n,
  input wire logic [7:0] byte_enables_n,
  input wire logic [31:3] addr,
  input wire logic data_code,
  input wire logic mem_io,
  input wire logic write_read,
  input wire logic burst_ready_n,
  input wire logic stop_clock_req_n
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ==========
  // Sequences
  sequence s_issue;
    !addr_strobe_n;
  endsequence
  sequence s_grant;
    !addr_strobe_n && addr[4:3] == 2'h2;
  endsequence
  // ==========
  // Checks
  chk_type_ind: assert property (s_issue |-> !data_code && !mem_io && write_read)
    else $error("special cycle type indicators wrong");
  chk_addr_high_zero: assert property (s_issue |-> addr[31:5] == 27'h0)
    else $error("special cycle upper address not zero");
  chk_be_legal: assert property (s_issue |-> byte_enables_n inside
    {8'hFB, 8'hEF, 8'hF7, 8'hFD, 8'hFE})
    else $error("special cycle byte enables not a known code");
  chk_grant_code: assert property (s_grant |-> byte_enables_n == 8'hFB)
    else $error("stop grant byte enables wrong");
  chk_ready_ack: assert property (s_issue |=> !burst_ready_n)
    else $error("no ready after special cycle strobe");
  chk_ready_cause: assert property ($fell(burst_ready_n) |-> $past(!addr_strobe_n))
    else $error("ready without a preceding strobe");
  chk_cycle_hold: assert property (s_issue |=> $stable(byte_enables_n) && write_read
    && $stable(addr) && addr_strobe_n)
    else $error("cycle fields changed before ready");
  chk_stop_held: assert property (s_grant |-> !stop_clock_req_n ##1 !stop_clock_req_n)
    else $error("stop request dropped before grant completed");
endmodule // scsc_assertions

// file: sim/tb_top.sv
// Self-checking bench joining the device and chipset ends over one link.
// Assumes the design files and the checker are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic bnd = 1'b1, halt_i = 1'b0, wbinv_i = 1'b0, inv_i = 1'b0, fault_i = 1'b0;
  logic pend = 1'b0, mask = 1'b0, stop_r = 1'b0, flush_r = 1'b0, wbuf = 1'b0;
  logic [2:0] wake = 3'h0;
  logic fetch, keep, stopped, halted, shut, wb, seen, gdone, pflush, cinv;
  logic [31:0] faddr;
  logic [7:0] cbe;
  logic [1:0] ca43;
  logic [9:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  int walk_cnt = 0;
  int pipe_cnt = 0;
  int mark;
  scsc_if scsc_if_i ();
  scsc_device scsc_device_i (.clock_in(clock_in), .srst_in(srst_in), .bus(scsc_if_i),
    .instr_boundary_in(bnd), .halt_instr_in(halt_i), .writeback_invalidate_instr_in(wbinv_i),
    .invalidate_instr_in(inv_i), .triple_fault_in(fault_i), .bus_pending_in(pend),
    .ext_write_buf_empty_n_mask_in(mask), .pipe_flush_out(pflush), .cache_writeback_out(wb),
    .cache_invalidate_out(cinv), .fetch_start_out(fetch), .fetch_addr_out(faddr),
    .init_keep_state_out(keep), .internal_clk_stopped_out(stopped),
    .halted_out(halted), .shutdown_out(shut));
  scsc_chipset scsc_chipset_i (.clock_in(clock_in), .srst_in(srst_in), .bus(scsc_if_i),
    .stop_req_in(stop_r), .flush_req_in(flush_r), .init_req_in(wake[1]),
    .nmi_in(wake[0]), .smi_in(wake[2]), .wbuf_empty_in(wbuf), .cycle_seen_out(seen),
    .cycle_be_n_out(cbe), .cycle_a43_out(ca43), .grant_done_out(gdone));
  scsc_assertions scsc_assertions_i (.clock_in(clock_in), .srst_in(srst_in),
    .addr_strobe_n(scsc_if_i.addr_strobe_n), .byte_enables_n(scsc_if_i.byte_enables_n),
    .addr(scsc_if_i.addr), .data_code(scsc_if_i.data_code), .mem_io(scsc_if_i.mem_io),
    .write_read(scsc_if_i.write_read), .burst_ready_n(scsc_if_i.burst_ready_n),
    .stop_clock_req_n(scsc_if_i.stop_clock_req_n));
  // ==========
  // Helpers
  initial forever #20 clock_in = ~clock_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock_in);
    s = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    repeat (300) if (s !== v) @(negedge clock_in);
  endtask
  // Every announced cycle must have appeared before the next test starts.
  task automatic drain();
    repeat (300) if (exp_q.size() > 0) @(negedge clock_in);
    chk(exp_q.size(), 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========
  // Observers
  always @(posedge clock_in) begin
    if (wb === 1'b1 && cinv === 1'b1) walk_cnt++;
    if (pflush === 1'b1) pipe_cnt++;
    if (seen === 1'b1) begin
      chk({22'h0, cbe, ca43}, exp_q.size() > 0 ? {22'h0, exp_q.pop_front()} : 32'hFFFFFFFF);
    end
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    report_and_stop();
  end
  // ==========
  // Tests
  initial begin
    void'($urandom(32'h8bf5));
    repeat (5) @(negedge clock_in);
    srst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    exp_q.push_back({8'hFB, 2'h0});
    pulse(halt_i);
    wait_for(halted, 1'b1);
    chk_bit(halted, 1'b1);
    wake[0] = 1'b1;
    wait_for(halted, 1'b0);
    wake[0] = 1'b0;
    drain();
    $display("test halt done");
    mark = walk_cnt;
    exp_q.push_back({8'hEF, 2'h0});
    pulse(flush_r);
    drain();
    chk_bit(walk_cnt - mark >= 8, 1'b1);
    mark = walk_cnt;
    exp_q.push_back({8'hF7, 2'h0});
    exp_q.push_back({8'hFD, 2'h0});
    pulse(wbinv_i);
    drain();
    chk_bit(walk_cnt - mark >= 8, 1'b1);
    exp_q.push_back({8'hFD, 2'h0});
    pulse(inv_i);
    drain();
    $display("test cache cycles done");
    // Init raised off a boundary must wait for one before fetching.
    bnd = 1'b0;
    wake[1] = 1'b1;
    @(negedge clock_in);
    wake[1] = 1'b0;
    repeat (6) begin
      @(negedge clock_in);
      chk_bit(fetch, 1'b0);
    end
    bnd = 1'b1;
    wait_for(fetch, 1'b1);
    chk_bit(fetch, 1'b1);
    chk(faddr, 32'hFFFFFFF0);
    chk_bit(keep, 1'b1);
    $display("test init done");
    for (int m = 0; m < 2; m++) begin
      mask = m[0];
      pend = 1'b1;
      mark = pipe_cnt;
      stop_r = 1'b1;
      exp_q.push_back({8'hFB, 2'h2});
      repeat ($urandom_range(2, 9)) begin
        @(negedge clock_in);
        chk_bit(scsc_if_i.addr_strobe_n, 1'b1);
      end
      pend = 1'b0;
      wait_for(gdone, 1'b1);
      chk_bit(gdone, 1'b1);
      chk(pipe_cnt - mark, 32'h1);
      drain();
      repeat (4) @(negedge clock_in);
      chk_bit(stopped, mask);
      wbuf = 1'b1;
      wait_for(stopped, 1'b1);
      chk_bit(stopped, 1'b1);
      stop_r = 1'b0;
      wbuf = 1'b0;
      wait_for(stopped, 1'b0);
      chk_bit(stopped, 1'b0);
    end
    $display("test stop grant done");
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back({8'hFE, 2'h0});
      pulse(fault_i);
      wait_for(shut, 1'b1);
      drain();
      chk_bit(shut, 1'b1);
      wake[k] = 1'b1;
      wait_for(shut, 1'b0);
      wake = 3'h0;
      chk_bit(shut, 1'b0);
      repeat (4) @(negedge clock_in);
    end
    $display("test shutdown done");
    report_and_stop();
  end
endmodule // tb_top
